//--- hdl/chan_event_mask.sv
/*
  Event, mask and buffer-close logic of one serial channel in
  transparent mode: one receive and one transmit descriptor.
  Assumes all inputs synchronous to CLK_SYS and a register master that
  never issues read and write strobes together.
*/
// Local design decisions: the address map and the plain strobed port.
`timescale 1ns/10ps
module chan_event_mask (
  // Clock and reset
  input  wire logic                     CLK_SYS,
  input  wire logic                     RST,
  // Register port
  input  wire logic [7:0]               REG_ADDR,
  input  wire logic [15:0]              REG_WDATA,
  input  wire logic                     REG_WR,
  input  wire logic                     REG_RD,
  output logic      [15:0]              REG_RDATA,
  // Receive character stream
  input  wire logic                     RX_CHAR_VALID,
  input  wire logic [7:0]               RX_CHAR,
  output chan_event_pkg::buf_wr_s       RX_BUF_WR,
  // Transmit character stream
  input  wire logic                     TX_FIFO_ROOM,
  input  wire logic                     TX_SHIFT_START,
  input  wire logic                     TX_UNDERRUN,
  output chan_event_pkg::tx_load_s      TX_LOAD,
  // Channel interrupt request
  output logic                          CHAN_IRQ
);

  function automatic logic [15:0] addr_plus(input logic [15:0] base,
                                            input logic [15:0] off);
    addr_plus = base + off;
  endfunction : addr_plus
  localparam logic [2:0] RST_OUT_C = chan_event_pkg::RST_OUT;
  logic [15:0] mode_q, mode_d;
  logic [7:0]  ev_q, ev_d;
  logic [7:0]  mask_q, mask_d;
  logic [15:0] rx_base_q, rx_base_d, tx_base_q, tx_base_d;
  logic [15:0] max_rx_q, max_rx_d;
  logic [15:0] rx_ptr_q, rx_ptr_d, tx_ptr_q, tx_ptr_d;
  logic        rx_empty_q, rx_empty_d;
  logic [15:0] rx_cnt_q, rx_cnt_d, rx_len_q, rx_len_d;
  logic        rx_close_q, rx_close_d;
  logic        txd_ready_q, txd_ready_d, txd_last_q, txd_last_d;
  logic [15:0] tx_len_q, tx_len_d, tx_cnt_q, tx_cnt_d;
  logic [2:0]  tx_out_q, tx_out_d, tx_left_q, tx_left_d;
  chan_event_pkg::tx_state_e tx_st_q, tx_st_d;
  logic [15:0] rdata_q, rdata_d;
  chan_event_pkg::buf_wr_s  rx_wr_q, rx_wr_d;
  chan_event_pkg::tx_load_s tx_ld_q, tx_ld_d;
  logic        irq_q, irq_d;
  logic        wr_ev, rx_acc, tx_fetch;
  logic [7:0]  ev_set;
  assign REG_RDATA = rdata_q;
  assign RX_BUF_WR = rx_wr_q;
  assign TX_LOAD   = tx_ld_q;
  assign CHAN_IRQ  = irq_q;
  assign wr_ev    = REG_WR && (REG_ADDR == chan_event_pkg::OFS_EVENT);
  assign rx_acc   = RX_CHAR_VALID && mode_q[chan_event_pkg::MODE_REN_BIT];
  assign tx_fetch = (tx_st_q == chan_event_pkg::TX_SEND) && TX_FIFO_ROOM
                    && mode_q[chan_event_pkg::MODE_TEN_BIT];
  always_comb begin
    mode_d      = mode_q;
    mask_d      = mask_q;
    rx_base_d   = rx_base_q;
    tx_base_d   = tx_base_q;
    max_rx_d    = max_rx_q;
    rx_ptr_d    = rx_ptr_q;
    tx_ptr_d    = tx_ptr_q;
    rx_empty_d  = rx_empty_q;
    rx_cnt_d    = rx_cnt_q;
    rx_len_d    = rx_len_q;
    rx_close_d  = 1'b0;
    txd_ready_d = txd_ready_q;
    txd_last_d  = txd_last_q;
    tx_len_d    = tx_len_q;
    tx_cnt_d    = tx_cnt_q;
    tx_out_d    = tx_out_q;
    tx_left_d   = tx_left_q;
    tx_st_d     = tx_st_q;
    ev_set      = chan_event_pkg::RST_BYTE;
    rx_wr_d     = '0;
    tx_ld_d     = '0;
    rdata_d     = chan_event_pkg::RST_WORD;

    // Register writes
    if (REG_WR) begin
      case (REG_ADDR)
        chan_event_pkg::OFS_MODE:    mode_d = REG_WDATA;
        chan_event_pkg::OFS_MASK:    mask_d = REG_WDATA[7:0];
        chan_event_pkg::OFS_RX_BASE: rx_base_d = REG_WDATA;
        chan_event_pkg::OFS_TX_BASE: tx_base_d = REG_WDATA;
        chan_event_pkg::OFS_MAX_RX:  max_rx_d = REG_WDATA;
        chan_event_pkg::OFS_COMMAND: begin
          if (REG_WDATA == chan_event_pkg::CMD_INIT) begin
            rx_ptr_d = rx_base_q;
            tx_ptr_d = tx_base_q;
          end
        end
        chan_event_pkg::OFS_RX_DESC: begin
          // A fresh empty buffer restarts reception
          if (REG_WDATA[chan_event_pkg::DESC_OWN_BIT]) begin
            rx_empty_d = 1'b1;
            rx_cnt_d   = chan_event_pkg::RST_WORD;
          end
        end
        chan_event_pkg::OFS_TX_DESC: begin
          txd_ready_d = REG_WDATA[chan_event_pkg::DESC_OWN_BIT];
          txd_last_d  = REG_WDATA[chan_event_pkg::TXD_LAST_BIT];
        end
        chan_event_pkg::OFS_TX_LEN:  tx_len_d = REG_WDATA;
        default: ;
      endcase
    end

    // Register reads, data stands in the following cycle only
    if (REG_RD) begin
      case (REG_ADDR)
        chan_event_pkg::OFS_MODE:    rdata_d = mode_q;
        chan_event_pkg::OFS_EVENT:   rdata_d = {8'h00, ev_q};
        chan_event_pkg::OFS_MASK:    rdata_d = {8'h00, mask_q};
        chan_event_pkg::OFS_RX_BASE: rdata_d = rx_base_q;
        chan_event_pkg::OFS_TX_BASE: rdata_d = tx_base_q;
        chan_event_pkg::OFS_MAX_RX:  rdata_d = max_rx_q;
        chan_event_pkg::OFS_RX_PTR:  rdata_d = rx_ptr_q;
        chan_event_pkg::OFS_TX_PTR:  rdata_d = tx_ptr_q;
        chan_event_pkg::OFS_RX_DESC: rdata_d = {rx_empty_q, 15'h0000};
        chan_event_pkg::OFS_TX_DESC: rdata_d = {txd_ready_q, 3'h0,
                                                txd_last_q, 11'h000};
        chan_event_pkg::OFS_TX_LEN:  rdata_d = tx_len_q;
        chan_event_pkg::OFS_RX_LEN:  rdata_d = rx_len_q;
        default:                     rdata_d = chan_event_pkg::RST_WORD;
      endcase
    end

    // Receive: store or discard each character
    if (rx_acc) begin
      if (rx_empty_q) begin
        rx_wr_d.valid = 1'b1;
        rx_wr_d.addr  = addr_plus(rx_ptr_q, rx_cnt_q);
        rx_wr_d.data  = RX_CHAR;
        rx_cnt_d      = rx_cnt_q + 16'h0001;
        if (rx_cnt_d >= max_rx_q) begin
          // Give up ownership now so no further byte lands in it
          rx_empty_d = 1'b0;
          rx_len_d   = rx_cnt_d;
          rx_close_d = 1'b1;
        end
      end else begin
        ev_set[chan_event_pkg::EV_BSY] = 1'b1;
      end
    end
    // Event follows the cycle in which the last byte is written
    if (rx_close_q) begin
      ev_set[chan_event_pkg::EV_RX] = 1'b1;
    end

    // Transmit: characters loaded but not yet shifting
    if (tx_fetch && !(TX_SHIFT_START && tx_out_q != RST_OUT_C)) begin
      tx_out_d = tx_out_q + 3'h1;
    end else if (!tx_fetch && TX_SHIFT_START && tx_out_q != RST_OUT_C) begin
      tx_out_d = tx_out_q - 3'h1;
    end

    case (tx_st_q)
      chan_event_pkg::TX_IDLE: begin
        if (txd_ready_q && tx_len_q != chan_event_pkg::RST_WORD) begin
          tx_st_d  = chan_event_pkg::TX_SEND;
          tx_cnt_d = chan_event_pkg::RST_WORD;
        end
      end
      chan_event_pkg::TX_SEND: begin
        if (tx_fetch) begin
          tx_ld_d.valid = 1'b1;
          tx_ld_d.addr  = addr_plus(tx_ptr_q, tx_cnt_q);
          tx_cnt_d      = tx_cnt_q + 16'h0001;
          if (tx_cnt_d == tx_len_q) begin
            txd_ready_d = 1'b0;
            if (txd_last_q) begin
              tx_left_d = tx_out_d;
              tx_st_d   = chan_event_pkg::TX_DRAIN;
            end else begin
              ev_set[chan_event_pkg::EV_TX] = 1'b1;
              tx_st_d = chan_event_pkg::TX_IDLE;
            end
          end
        end
      end
      chan_event_pkg::TX_DRAIN: begin
        if (TX_SHIFT_START) begin
          tx_left_d = tx_left_q - 3'h1;
          if (tx_left_q <= 3'h1) begin
            ev_set[chan_event_pkg::EV_TX] = 1'b1;
            tx_st_d = chan_event_pkg::TX_IDLE;
          end
        end
      end
      default: tx_st_d = chan_event_pkg::TX_IDLE;
    endcase

    if (TX_UNDERRUN) begin
      ev_set[chan_event_pkg::EV_TXE] = 1'b1;
    end

    // Write-one-to-clear; a same-cycle event wins over the clear
    ev_d = ((ev_q & ~(wr_ev ? REG_WDATA[7:0] : 8'h00)) | ev_set)
           & chan_event_pkg::EV_IMPL;
    irq_d = |(ev_d & mask_d);
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      mode_q      <= chan_event_pkg::RST_WORD;
      ev_q        <= chan_event_pkg::RST_BYTE;
      mask_q      <= chan_event_pkg::RST_BYTE;
      rx_base_q   <= chan_event_pkg::RST_WORD;
      tx_base_q   <= chan_event_pkg::RST_WORD;
      max_rx_q    <= chan_event_pkg::RST_WORD;
      rx_ptr_q    <= chan_event_pkg::RST_WORD;
      tx_ptr_q    <= chan_event_pkg::RST_WORD;
      rx_empty_q  <= 1'b0;
      rx_cnt_q    <= chan_event_pkg::RST_WORD;
      rx_len_q    <= chan_event_pkg::RST_WORD;
      rx_close_q  <= 1'b0;
      txd_ready_q <= 1'b0;
      txd_last_q  <= 1'b0;
      tx_len_q    <= chan_event_pkg::RST_WORD;
      tx_cnt_q    <= chan_event_pkg::RST_WORD;
      tx_out_q    <= RST_OUT_C;
      tx_left_q   <= RST_OUT_C;
      tx_st_q     <= chan_event_pkg::TX_IDLE;
      rdata_q     <= chan_event_pkg::RST_WORD;
      rx_wr_q     <= '0;
      tx_ld_q     <= '0;
      irq_q       <= 1'b0;
    end else begin
      mode_q      <= mode_d;
      ev_q        <= ev_d;
      mask_q      <= mask_d;
      rx_base_q   <= rx_base_d;
      tx_base_q   <= tx_base_d;
      max_rx_q    <= max_rx_d;
      rx_ptr_q    <= rx_ptr_d;
      tx_ptr_q    <= tx_ptr_d;
      rx_empty_q  <= rx_empty_d;
      rx_cnt_q    <= rx_cnt_d;
      rx_len_q    <= rx_len_d;
      rx_close_q  <= rx_close_d;
      txd_ready_q <= txd_ready_d;
      txd_last_q  <= txd_last_d;
      tx_len_q    <= tx_len_d;
      tx_cnt_q    <= tx_cnt_d;
      tx_out_q    <= tx_out_d;
      tx_left_q   <= tx_left_d;
      tx_st_q     <= tx_st_d;
      rdata_q     <= rdata_d;
      rx_wr_q     <= rx_wr_d;
      tx_ld_q     <= tx_ld_d;
      irq_q       <= irq_d;
    end
  end

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  sequence rx_last_byte;
    rx_acc && rx_empty_q && (rx_cnt_q + 16'h0001 >= max_rx_q);
  endsequence
  sequence write_then_event;
    RX_BUF_WR.valid ##1 ev_q[chan_event_pkg::EV_RX];
  endsequence
  busy_discard_a: assert property (
    rx_acc && !rx_empty_q |=> ev_q[chan_event_pkg::EV_BSY]
                              && !RX_BUF_WR.valid)
    else $error("Busy character not discarded and flagged");
  busy_resume_a: assert property (
    REG_WR && REG_ADDR == chan_event_pkg::OFS_RX_DESC
    && REG_WDATA[chan_event_pkg::DESC_OWN_BIT] ##1 rx_acc
    |=> RX_BUF_WR.valid)
    else $error("Reception did not resume on new buffer");
  rx_close_order_a: assert property (
    rx_last_byte |=> write_then_event)
    else $error("Receive event not after last byte written");
  rx_no_overwrite_a: assert property (
    rx_last_byte ##1 rx_acc |=> !RX_BUF_WR.valid)
    else $error("Closed receive buffer was written");
  tx_last_evt_a: assert property (
    tx_st_q == chan_event_pkg::TX_DRAIN && TX_SHIFT_START
    && tx_left_q == 3'h1 |=> ev_q[chan_event_pkg::EV_TX])
    else $error("Transmit event missing at final start");
  tx_load_close_a: assert property (
    tx_fetch && !txd_last_q && tx_cnt_q + 16'h0001 == tx_len_q
    |=> ev_q[chan_event_pkg::EV_TX] && !txd_ready_q)
    else $error("Transmit descriptor not closed at length");
  mask_reset_a: assert property (
    $fell(RST) |-> mask_q == 8'h00 && !CHAN_IRQ)
    else $error("Mask not clear after reset");
  irq_gate_a: assert property (
    CHAN_IRQ == |(ev_q & mask_q))
    else $error("Request does not match masked events");
  w1c_keep_a: assert property (
    wr_ev |=> (($past(ev_q) & ~$past(REG_WDATA[7:0])) & ~ev_q) == 8'h00)
    else $error("Event bit cleared without a one written");
  irq_hold_a: assert property (
    CHAN_IRQ && !REG_WR |=> CHAN_IRQ)
    else $error("Request dropped with events pending");
  underrun_flag_a: assert property (
    TX_UNDERRUN |=> ev_q[chan_event_pkg::EV_TXE])
    else $error("Underrun did not set transmit error");
  init_reload_a: assert property (
    REG_WR && REG_ADDR == chan_event_pkg::OFS_COMMAND
    && REG_WDATA == chan_event_pkg::CMD_INIT
    |=> rx_ptr_q == $past(rx_base_q) && tx_ptr_q == $past(tx_base_q))
    else $error("Init command did not reload pointers");
endmodule : chan_event_mask

//--- inc/chan_event_pkg.sv
/*
  Constants, register map and carrier types for the serial channel
  event and mask block.
  Assumes a single 10 MHz system clock and a 16-bit register port.
*/
package chan_event_pkg;

  // Register indices on the register port
  localparam logic [7:0] OFS_MODE     = 8'h00;
  localparam logic [7:0] OFS_EVENT    = 8'h01;
  localparam logic [7:0] OFS_MASK     = 8'h02;
  localparam logic [7:0] OFS_COMMAND  = 8'h03;
  localparam logic [7:0] OFS_RX_BASE  = 8'h04;
  localparam logic [7:0] OFS_TX_BASE  = 8'h05;
  localparam logic [7:0] OFS_MAX_RX   = 8'h06;
  localparam logic [7:0] OFS_RX_PTR   = 8'h07;
  localparam logic [7:0] OFS_TX_PTR   = 8'h08;
  localparam logic [7:0] OFS_RX_DESC  = 8'h09;
  localparam logic [7:0] OFS_TX_DESC  = 8'h0A;
  localparam logic [7:0] OFS_TX_LEN   = 8'h0B;
  localparam logic [7:0] OFS_RX_LEN   = 8'h0C;

  // Event and mask bit positions
  localparam int unsigned EV_RX  = 0;
  localparam int unsigned EV_TX  = 1;
  localparam int unsigned EV_BSY = 2;
  localparam int unsigned EV_TXE = 4;
  localparam logic [7:0]  EV_IMPL = 8'h17;

  // Mode, descriptor and command fields
  localparam int unsigned MODE_REN_BIT  = 0;
  localparam int unsigned MODE_TEN_BIT  = 1;
  localparam int unsigned DESC_OWN_BIT  = 15;
  localparam int unsigned TXD_LAST_BIT  = 11;
  localparam logic [15:0] CMD_INIT      = 16'h0001;

  // Values after reset
  localparam logic [7:0]  RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [2:0]  RST_OUT  = 3'h0;

  typedef enum logic [1:0] {TX_IDLE, TX_SEND, TX_DRAIN} tx_state_e;

  // Character write into the receive buffer memory
  typedef struct packed {
    logic        valid;
    logic [15:0] addr;
    logic [7:0]  data;
  } buf_wr_s;

  // Character fetch into the transmit FIFO
  typedef struct packed {
    logic        valid;
    logic [15:0] addr;
  } tx_load_s;

endpackage : chan_event_pkg

//--- verification/chan_line_peer.sv
/*
  Serial line peer model: transmit FIFO and shifter facing the channel.
  Assumes one character per TX_LOAD pulse and a synchronous reset.
*/
`timescale 1ns/10ps
module chan_line_peer (
  // Clock and reset
  input  wire logic                     clk,
  input  wire logic                     rst,
  // Bench control
  input  wire logic                     shift_go,
  // Channel side
  input  wire chan_event_pkg::tx_load_s tx_load,
  output logic                          fifo_room,
  output logic                          shift_start
);
  logic [1:0] cyc_q;
  logic [3:0] pend_q;

  // One character time is four clocks; room drops once per character
  // so the channel has to stall now and then
  always_ff @(posedge clk) begin
    if (rst) begin
      cyc_q       <= 2'h0;
      pend_q      <= 4'h0;
      fifo_room   <= 1'b0;
      shift_start <= 1'b0;
    end else begin
      cyc_q       <= cyc_q + 2'h1;
      fifo_room   <= (cyc_q != 2'h2);
      // Only loaded characters start shifting
      shift_start <= shift_go && (pend_q != 4'h0) && (cyc_q == 2'h0);
      pend_q      <= pend_q + 4'(tx_load.valid) - 4'(shift_start);
    end
  end
endmodule : chan_line_peer

//--- verification/tb_chan_event_mask.sv
/*
  Self-checking bench for the channel event and mask block.
  Assumes the line peer model beside it and a 10 MHz system clock.
*/
`timescale 1ns/10ps
module tb_chan_event_mask;
  typedef struct packed {
    logic [7:0]  wa;
    logic [15:0] wd;
    logic [7:0]  ra;
    logic [15:0] ex;
  } row_s;

  logic                     CLK_SYS, RST, REG_WR, REG_RD, CHAN_IRQ;
  logic                     RX_CHAR_VALID, TX_UNDERRUN, shift_go;
  logic                     TX_FIFO_ROOM, TX_SHIFT_START;
  logic [7:0]               REG_ADDR, RX_CHAR;
  logic [15:0]              REG_WDATA, REG_RDATA, rdat, tx_base;
  chan_event_pkg::buf_wr_s  RX_BUF_WR;
  chan_event_pkg::tx_load_s TX_LOAD;
  int                       bad_count, n_compared, tx_n, k;
  logic [31:0]              central_int_mask_reg, central_in_service_reg;

  row_s rows [0:8] = '{
    '{8'h02, 16'h00a5, 8'h02, 16'h00a5},
    '{8'h02, 16'h005a, 8'h02, 16'h005a},
    '{8'h03, 16'h0000, 8'h03, 16'h0000},
    '{8'h20, 16'hffff, 8'h20, 16'h0000},
    '{8'h04, 16'h1000, 8'h04, 16'h1000},
    '{8'h05, 16'h2000, 8'h05, 16'h2000},
    '{8'h06, 16'h0010, 8'h06, 16'h0010},
    '{8'h07, 16'hffff, 8'h07, 16'h0000},
    '{8'h01, 16'h00ff, 8'h01, 16'h0000}};

  chan_event_mask dut (
    .CLK_SYS(CLK_SYS), .RST(RST), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
    .REG_RDATA(REG_RDATA), .RX_CHAR_VALID(RX_CHAR_VALID),
    .RX_CHAR(RX_CHAR), .RX_BUF_WR(RX_BUF_WR),
    .TX_FIFO_ROOM(TX_FIFO_ROOM), .TX_SHIFT_START(TX_SHIFT_START),
    .TX_UNDERRUN(TX_UNDERRUN), .TX_LOAD(TX_LOAD), .CHAN_IRQ(CHAN_IRQ));

  chan_line_peer peer (
    .clk(CLK_SYS), .rst(RST), .shift_go(shift_go), .tx_load(TX_LOAD),
    .fifo_room(TX_FIFO_ROOM), .shift_start(TX_SHIFT_START));

  initial begin
    CLK_SYS = 1'b0;
    forever #50 CLK_SYS = ~CLK_SYS;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic results();
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : results

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge CLK_SYS);
    REG_WR    <= 1'b1;
    REG_ADDR  <= a;
    REG_WDATA <= d;
    @(posedge CLK_SYS);
    REG_WR    <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge CLK_SYS);
    REG_RD   <= 1'b1;
    REG_ADDR <= a;
    @(posedge CLK_SYS);
    REG_RD   <= 1'b0;
    #1;
    d = REG_RDATA;
  endtask : rd

  task automatic rchk(input logic [7:0] a, input logic [15:0] exp);
    rd(a, rdat);
    chk(rdat, exp);
  endtask : rchk

  task automatic rx(input logic [7:0] c);
    @(posedge CLK_SYS);
    RX_CHAR_VALID <= 1'b1;
    RX_CHAR       <= c;
    @(posedge CLK_SYS);
    RX_CHAR_VALID <= 1'b0;
    #1;
  endtask : rx

  task automatic wait_loads(input int n);
    for (k = 0; k < 200 && tx_n < n; k++) @(posedge CLK_SYS);
    if (tx_n < n) begin
      bad_count++;
      results();
    end
  endtask : wait_loads

  // Sampled mid-cycle, away from the edge that moves TX_LOAD
  always @(negedge CLK_SYS) begin
    if (TX_LOAD.valid === 1'b1) begin
      chk(TX_LOAD.addr, tx_base + 16'(tx_n));
      tx_n++;
    end
  end

  initial begin
    RST = 1'b1; REG_ADDR = 8'h00; REG_WDATA = 16'h0000; REG_WR = 1'b0;
    REG_RD = 1'b0; RX_CHAR_VALID = 1'b0; RX_CHAR = 8'h00;
    TX_UNDERRUN = 1'b0; shift_go = 1'b0; tx_n = 0; tx_base = 16'h2000;
    bad_count = 0; n_compared = 0;
    central_int_mask_reg   = 32'h0000_0000;
    central_in_service_reg = 32'h0000_0000;
    repeat (6) @(posedge CLK_SYS);
    RST <= 1'b0;
    rchk(chan_event_pkg::OFS_MASK, 16'h0000);
    rchk(chan_event_pkg::OFS_EVENT, 16'h0000);
    chk(16'(CHAN_IRQ), 16'h0000);
    foreach (rows[i]) begin
      wr(rows[i].wa, rows[i].wd);
      rchk(rows[i].ra, rows[i].ex);
    end
    wr(chan_event_pkg::OFS_COMMAND, chan_event_pkg::CMD_INIT);
    rchk(chan_event_pkg::OFS_RX_PTR, 16'h1000);
    rchk(chan_event_pkg::OFS_TX_PTR, 16'h2000);
    wr(chan_event_pkg::OFS_MODE, 16'h3830);
    wr(chan_event_pkg::OFS_MODE, 16'h3833);
    wr(chan_event_pkg::OFS_EVENT, 16'h00ff);
    wr(chan_event_pkg::OFS_MASK, 16'h0013);
    central_int_mask_reg = 32'h0000_0010;
    $display("register test done");
    wr(chan_event_pkg::OFS_RX_DESC, 16'h8000);
    for (int i = 0; i < 15; i++) begin
      rx(8'h40 + 8'(i));
      chk(16'(RX_BUF_WR.valid), 16'h0001);
      chk(RX_BUF_WR.addr, 16'h1000 + 16'(i));
      chk(16'(RX_BUF_WR.data), 16'h0040 + 16'(i));
    end
    // Back to back, so the closed buffer meets a byte at once
    @(posedge CLK_SYS);
    RX_CHAR_VALID <= 1'b1;
    RX_CHAR       <= 8'h4f;
    @(posedge CLK_SYS);
    RX_CHAR       <= 8'h99;
    #1;
    chk(16'(RX_BUF_WR.valid), 16'h0001);
    chk(RX_BUF_WR.addr, 16'h100f);
    chk(16'(RX_BUF_WR.data), 16'h004f);
    @(posedge CLK_SYS);
    RX_CHAR_VALID <= 1'b0;
    #1;
    chk(16'(RX_BUF_WR.valid), 16'h0000);
    rchk(chan_event_pkg::OFS_EVENT, 16'h0005);
    rchk(chan_event_pkg::OFS_RX_LEN, 16'h0010);
    rchk(chan_event_pkg::OFS_RX_DESC, 16'h0000);
    chk(16'(CHAN_IRQ), 16'h0001);
    chk(16'(CHAN_IRQ & central_int_mask_reg[4]), 16'h0001);
    central_in_service_reg[4] = CHAN_IRQ;
    wr(chan_event_pkg::OFS_EVENT, 16'h0001);
    chk(16'(CHAN_IRQ), 16'h0000);
    central_in_service_reg[4] = 1'b0;
    wr(chan_event_pkg::OFS_EVENT, 16'h0000);
    rchk(chan_event_pkg::OFS_EVENT, 16'h0004);
    wr(chan_event_pkg::OFS_MASK, 16'h0004);
    chk(16'(CHAN_IRQ), 16'h0001);
    wr(chan_event_pkg::OFS_EVENT, 16'h0004);
    chk(16'(CHAN_IRQ), 16'h0000);
    wr(chan_event_pkg::OFS_MASK, 16'h0013);
    // Fresh buffer, then a character in the very next cycle
    @(posedge CLK_SYS);
    REG_WR        <= 1'b1;
    REG_ADDR      <= chan_event_pkg::OFS_RX_DESC;
    REG_WDATA     <= 16'h8000;
    @(posedge CLK_SYS);
    REG_WR        <= 1'b0;
    RX_CHAR_VALID <= 1'b1;
    RX_CHAR       <= 8'h77;
    @(posedge CLK_SYS);
    RX_CHAR_VALID <= 1'b0;
    #1;
    chk(16'(RX_BUF_WR.valid), 16'h0001);
    chk(RX_BUF_WR.addr, 16'h1000);
    $display("receive test done");
    wr(chan_event_pkg::OFS_EVENT, 16'h00ff);
    // Shifter held still: the event may only come from the FIFO load
    wr(chan_event_pkg::OFS_TX_LEN, 16'h0005);
    wr(chan_event_pkg::OFS_TX_DESC, 16'h8000);
    wait_loads(5);
    rchk(chan_event_pkg::OFS_EVENT, 16'h0002);
    rchk(chan_event_pkg::OFS_TX_DESC, 16'h0000);
    wr(chan_event_pkg::OFS_EVENT, 16'h00ff);
    tx_n = 0;
    wr(chan_event_pkg::OFS_TX_LEN, 16'h0002);
    wr(chan_event_pkg::OFS_TX_DESC, 16'h8800);
    wait_loads(2);
    rchk(chan_event_pkg::OFS_EVENT, 16'h0000);
    @(posedge CLK_SYS);
    shift_go <= 1'b1;
    for (k = 0; k < 100 && CHAN_IRQ !== 1'b1; k++) @(posedge CLK_SYS);
    chk(16'(CHAN_IRQ), 16'h0001);
    rchk(chan_event_pkg::OFS_EVENT, 16'h0002);
    rchk(chan_event_pkg::OFS_TX_DESC, 16'h0800);
    $display("transmit test done");
    wr(chan_event_pkg::OFS_EVENT, 16'h00ff);
    @(posedge CLK_SYS);
    TX_UNDERRUN <= 1'b1;
    @(posedge CLK_SYS);
    TX_UNDERRUN <= 1'b0;
    rchk(chan_event_pkg::OFS_EVENT, 16'h0010);
    chk(16'(CHAN_IRQ), 16'h0001);
    @(posedge CLK_SYS);
    RST <= 1'b1;
    repeat (2) @(posedge CLK_SYS);
    RST <= 1'b0;
    rchk(chan_event_pkg::OFS_MASK, 16'h0000);
    chk(16'(CHAN_IRQ), 16'h0000);
    $display("underrun and reset test done");
    results();
  end
endmodule : tb_chan_event_mask
